// ---- dmach_top.sv ----
// Chosen here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "dmach_cfg.svh"
// How it works
// - Data moves only when controller enable and channel enable are both set.
// - Writing one to the force bit starts a transfer from software.
// - A selected device interrupt starts a transfer when start-IRQ enable is set.
// - Each start event moves one cell of bytes, then waits for the next.
// - Source size zero means 256 bytes, otherwise its value.
// - Destination size zero means 256 bytes, otherwise its value.
// - Cell size zero means 256 bytes per event, otherwise its value.
// - Read-only source and destination pointers update after each transaction.
// - Read-only cell progress counts bytes moved since the last start event, and reads zero after block end.
// - A pattern match resets the source pointer and cell progress.
// - The match byte is used only when pattern termination is enabled.
// - Half and done flags rise when a pointer reaches half or full size.
// - Pointers clear on reset and while the controller enable is zero.
// - Pointers clear on block completion or pattern match, whatever auto-enable holds.
// - Abort clears pointers, except while channel-disabled or suspended mid-transfer.
// - Writing a start address resets the matching pointer.
// - Block end clears channel enable unless auto-enable; disabled channel stays idle.
// - Abort write, match, abort IRQ, address error or block end stop a transfer.
// - An abort sets the abort flag after the running transaction finishes.
// - A transaction is one read then one write of up to four bytes.
// - A block ends after the larger of source and destination size.
// - Pointers wrap at their sizes; a cell never exceeds the block size.
// - A match sets the block complete flag and clears enable without auto-enable.
// - A match is any byte moved in the transaction equal to the match byte.
module dmach_top
    import dmach_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        dev_irq_valid,
    input  wire logic [7:0]  dev_irq_num,
    output logic             m_read,
    output logic             m_write,
    output logic      [31:0] m_address,
    output logic      [31:0] m_writedata,
    output logic      [3:0]  m_byteenable,
    input  wire logic [31:0] m_readdata,
    input  wire logic        m_waitrequest,
    input  wire logic        m_error,
    output logic             chan_irq
);

    dmach_regs_type s_r;
    dmach_regs_type s_nxt;

    ////////////////////////////////////////////////////////////////////////////////////////////

    // Size field to byte count; zero stands for 256.
    function automatic logic [8:0] len9(input logic [7:0] v);
        len9 = (v == 8'h00) ? 9'h100 : {1'b0, v};
    endfunction

    // Byte-lane merge of a bus write into a stored word.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        for (int i = 0; i < 4; i++)
            merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    endfunction

    logic [8:0] slen;
    logic [8:0] dlen;
    logic [8:0] clen;
    logic [8:0] blen;
    logic [8:0] cell_eff;
    logic [8:0] src_left;
    logic [8:0] dst_left;
    logic [8:0] cell_left;
    logic [3:0] byte_hit;
    logic       match;
    logic       run_ok;
    logic       start_ev;
    logic       abort_irq;
    logic       wr_acc;

    assign slen     = len9(s_r.ssiz);
    assign dlen     = len9(s_r.dsiz);
    assign clen     = len9(s_r.csiz);
    assign blen     = (slen > dlen) ? slen : dlen;
    assign cell_eff = (clen > blen) ? blen : clen;
    assign src_left = slen - {1'b0, s_r.sptr};
    assign dst_left = dlen - {1'b0, s_r.dptr};
    assign cell_left = cell_eff - s_r.cptr;
    assign run_ok   = s_r.gon && s_r.ctrl[`DMACH_CHANNEL_ENABLE_BIT] && !s_r.gsusp;
    assign wr_acc   = avs_write && !avs_waitrequest;
    assign abort_irq = dev_irq_valid && s_r.econ[`DMACH_ABORT_IRQ_ENABLE_BIT]
                     && (dev_irq_num == s_r.econ[23:16]);
    assign start_ev = (wr_acc && avs_address == `DMACH_ECON_OFS && avs_byteenable[0]
                       && avs_writedata[`DMACH_FORCE_BIT])
                    || (dev_irq_valid && s_r.econ[`DMACH_START_IRQ_ENABLE_BIT]
                       && dev_irq_num == s_r.econ[15:8]);

    generate
        for (genvar g = 0; g < 4; g++)
        begin : g_match
            assign byte_hit[g] = (g < s_r.nbytes)
                               && (s_r.rdata[g*8 +: 8] == s_r.mdat);
        end
    endgenerate
    assign match = s_r.econ[`DMACH_MATCH_TERMINATE_ENABLE_BIT] && (|byte_hit);

    ////////////////////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        logic [8:0] n;
        logic [8:0] nsp;
        logic [8:0] ndp;
        logic       blk_end;
        logic       clr_ptr;
        n       = 9'h000;
        nsp     = 9'h000;
        ndp     = 9'h000;
        blk_end = 1'b0;
        clr_ptr = 1'b0;
        s_nxt   = s_r;

        // Register writes.
        if (wr_acc)
        begin
            if (avs_address == `DMACH_CTRL_OFS)
                s_nxt.ctrl = merge(s_r.ctrl, avs_writedata, avs_byteenable) & 32'h0000_0090;
            else if (avs_address == `DMACH_ECON_OFS)
            begin
                s_nxt.econ = merge(s_r.econ, avs_writedata, avs_byteenable) & 32'h00FF_FF38;
                if (avs_byteenable[0] && avs_writedata[`DMACH_ABORT_BIT])
                    s_nxt.pend_abort = 1'b1;
            end
            else if (avs_address == `DMACH_INT_OFS)
            begin
                s_nxt.intr[23:16] = avs_byteenable[2] ? avs_writedata[23:16] : s_r.intr[23:16];
                if (avs_byteenable[0])
                    s_nxt.intr[7:0] = s_r.intr[7:0] & ~avs_writedata[7:0];
            end
            else if (avs_address == `DMACH_SSA_OFS)
            begin
                s_nxt.ssa  = merge(s_r.ssa, avs_writedata, avs_byteenable);
                s_nxt.sptr = 8'h00;
            end
            else if (avs_address == `DMACH_DSA_OFS)
            begin
                s_nxt.dsa  = merge(s_r.dsa, avs_writedata, avs_byteenable);
                s_nxt.dptr = 8'h00;
            end
            else if (avs_address == `DMACH_SSIZ_OFS && avs_byteenable[0])
                s_nxt.ssiz = avs_writedata[7:0];
            else if (avs_address == `DMACH_DSIZ_OFS && avs_byteenable[0])
                s_nxt.dsiz = avs_writedata[7:0];
            else if (avs_address == `DMACH_CSIZ_OFS && avs_byteenable[0])
                s_nxt.csiz = avs_writedata[7:0];
            else if (avs_address == `DMACH_MDAT_OFS && avs_byteenable[0])
                s_nxt.mdat = avs_writedata[7:0];
            else if (avs_address == `DMACH_GCTRL_OFS && avs_byteenable[1])
            begin
                s_nxt.gon   = avs_writedata[`DMACH_GON_BIT];
                s_nxt.gsusp = avs_writedata[`DMACH_GSUSP_BIT];
            end
        end
        if (abort_irq)
            s_nxt.pend_abort = 1'b1;

        // Transfer engine.
        case (s_r.state)
            DMACH_IDLE:
            begin
                if (s_r.pend_abort)
                begin
                    s_nxt.pend_abort = 1'b0;
                    s_nxt.intr[`DMACH_FLAG_ABORT] = 1'b1;
                    // A cell cut short by channel disable or suspend keeps its pointers.
                    if (!(s_r.cell_busy && !run_ok))
                    begin
                        clr_ptr         = 1'b1;
                        s_nxt.cptr      = 9'h000;
                        s_nxt.cell_busy = 1'b0;
                    end
                end
                else if (run_ok && (s_r.cell_busy || start_ev))
                begin
                    n = s_r.cell_busy ? cell_left : cell_eff;
                    if (src_left < n) n = src_left;
                    if (dst_left < n) n = dst_left;
                    if (n > `DMACH_WORD_BYTES) n = `DMACH_WORD_BYTES;
                    s_nxt.nbytes = n;
                    s_nxt.maddr  = s_r.ssa + {24'h000000, s_r.sptr};
                    s_nxt.mread  = 1'b1;
                    s_nxt.mbe    = 4'hF;
                    if (!s_r.cell_busy)
                        s_nxt.cptr = 9'h000;
                    s_nxt.cell_busy = 1'b1;
                    s_nxt.state  = DMACH_READ;
                end
            end
            DMACH_READ:
            begin
                if (!m_waitrequest)
                begin
                    s_nxt.mread = 1'b0;
                    if (m_error)
                    begin
                        s_nxt.intr[`DMACH_FLAG_ADDR_ERR] = 1'b1;
                        s_nxt.ctrl[`DMACH_CHANNEL_ENABLE_BIT] = 1'b0;
                        s_nxt.cptr  = 9'h000;
                        s_nxt.cell_busy = 1'b0;
                        s_nxt.state = DMACH_IDLE;
                    end
                    else
                    begin
                        s_nxt.rdata  = m_readdata;
                        s_nxt.mwrite = 1'b1;
                        s_nxt.maddr  = s_r.dsa + {24'h000000, s_r.dptr};
                        s_nxt.mwdata = m_readdata;
                        s_nxt.mbe    = 4'(({4'h0, 4'hF} << s_r.nbytes[2:0]) >> 4);
                        s_nxt.state  = DMACH_WRITE;
                    end
                end
            end
            DMACH_WRITE:
            begin
                if (!m_waitrequest)
                begin
                    s_nxt.mwrite = 1'b0;
                    s_nxt.state  = DMACH_IDLE;
                    if (m_error)
                    begin
                        s_nxt.intr[`DMACH_FLAG_ADDR_ERR] = 1'b1;
                        s_nxt.ctrl[`DMACH_CHANNEL_ENABLE_BIT] = 1'b0;
                        s_nxt.cptr = 9'h000;
                        s_nxt.cell_busy = 1'b0;
                    end
                    else
                    begin
                        nsp = {1'b0, s_r.sptr} + s_r.nbytes;
                        ndp = {1'b0, s_r.dptr} + s_r.nbytes;
                        s_nxt.cptr = s_r.cptr + s_r.nbytes;
                        s_nxt.bcnt = s_r.bcnt + s_r.nbytes;
                        if (nsp == (slen >> 1) && slen != 9'h001)
                            s_nxt.intr[`DMACH_FLAG_SHALF] = 1'b1;
                        if (ndp == (dlen >> 1) && dlen != 9'h001)
                            s_nxt.intr[`DMACH_FLAG_DHALF] = 1'b1;
                        if (nsp == slen)
                            s_nxt.intr[`DMACH_FLAG_SDONE] = 1'b1;
                        if (ndp == dlen)
                            s_nxt.intr[`DMACH_FLAG_DDONE] = 1'b1;
                        s_nxt.sptr = (nsp >= slen) ? 8'h00 : nsp[7:0];
                        s_nxt.dptr = (ndp >= dlen) ? 8'h00 : ndp[7:0];
                        blk_end = (s_r.bcnt + s_r.nbytes >= blen) || match;
                        if (s_r.cptr + s_r.nbytes >= cell_eff || blk_end)
                        begin
                            s_nxt.cell_busy = 1'b0;
                            s_nxt.intr[`DMACH_FLAG_CELL] = 1'b1;
                        end
                        if (blk_end)
                        begin
                            s_nxt.cptr = 9'h000;
                            s_nxt.intr[`DMACH_FLAG_BLOCK] = 1'b1;
                            clr_ptr = 1'b1;
                            if (!s_r.ctrl[`DMACH_AEN_BIT])
                                s_nxt.ctrl[`DMACH_CHANNEL_ENABLE_BIT] = 1'b0;
                        end
                    end
                end
            end
            default:
                s_nxt.state = DMACH_IDLE;
        endcase

        if (clr_ptr || !s_r.gon)
        begin
            s_nxt.sptr = 8'h00;
            s_nxt.dptr = 8'h00;
            s_nxt.bcnt = 9'h000;
        end

        // Register read data, captured in the wait cycle before acceptance.
        s_nxt.rvalid = avs_read && !s_r.rvalid;
        s_nxt.rdata  = (s_r.state == DMACH_READ && !m_waitrequest) ? s_nxt.rdata : s_r.rdata;
        s_nxt.word   = `DMACH_RST_WORD;
        if (avs_address == `DMACH_CTRL_OFS)
            s_nxt.word = s_r.ctrl;
        else if (avs_address == `DMACH_ECON_OFS)
            s_nxt.word = s_r.econ;
        else if (avs_address == `DMACH_INT_OFS)
            s_nxt.word = {8'h00, s_r.intr};
        else if (avs_address == `DMACH_SSA_OFS)
            s_nxt.word = s_r.ssa;
        else if (avs_address == `DMACH_DSA_OFS)
            s_nxt.word = s_r.dsa;
        else if (avs_address == `DMACH_SSIZ_OFS)
            s_nxt.word = {24'h000000, s_r.ssiz};
        else if (avs_address == `DMACH_DSIZ_OFS)
            s_nxt.word = {24'h000000, s_r.dsiz};
        else if (avs_address == `DMACH_SPTR_OFS)
            s_nxt.word = {24'h000000, s_r.sptr};
        else if (avs_address == `DMACH_DPTR_OFS)
            s_nxt.word = {24'h000000, s_r.dptr};
        else if (avs_address == `DMACH_CSIZ_OFS)
            s_nxt.word = {24'h000000, s_r.csiz};
        else if (avs_address == `DMACH_CPTR_OFS)
            s_nxt.word = {24'h000000, s_r.cptr[7:0]};
        else if (avs_address == `DMACH_MDAT_OFS)
            s_nxt.word = {24'h000000, s_r.mdat};
        else if (avs_address == `DMACH_GCTRL_OFS)
            s_nxt.word = {16'h0000, s_r.gon, 2'b00, s_r.gsusp, 12'h000};
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////////////////////

    // Reads take one wait cycle; writes are accepted at once.
    assign avs_waitrequest = avs_read && !s_r.rvalid;
    assign avs_readdata    = s_r.word;
    assign m_read          = s_r.mread;
    assign m_write         = s_r.mwrite;
    assign m_address       = s_r.maddr;
    assign m_writedata     = s_r.mwdata;
    assign m_byteenable    = s_r.mbe;
    assign chan_irq        = |(s_r.intr[7:0] & s_r.intr[23:16]);

endmodule

// ---- dmach_cfg.svh ----
`ifndef DMACH_CFG_SVH
`define DMACH_CFG_SVH

// Register byte offsets.
`define DMACH_CTRL_OFS      8'h00
`define DMACH_ECON_OFS      8'h04
`define DMACH_INT_OFS       8'h08
`define DMACH_SSA_OFS       8'h0C
`define DMACH_DSA_OFS       8'h10
`define DMACH_SSIZ_OFS      8'h14
`define DMACH_DSIZ_OFS      8'h18
`define DMACH_SPTR_OFS      8'h1C
`define DMACH_DPTR_OFS      8'h20
`define DMACH_CSIZ_OFS      8'h24
`define DMACH_CPTR_OFS      8'h28
`define DMACH_MDAT_OFS      8'h2C
`define DMACH_GCTRL_OFS     8'h30

// Field positions.
`define DMACH_GON_BIT       15
`define DMACH_GSUSP_BIT     12
`define DMACH_CHANNEL_ENABLE_BIT      7
`define DMACH_AEN_BIT       4
`define DMACH_FORCE_BIT     7
`define DMACH_ABORT_BIT     6
`define DMACH_MATCH_TERMINATE_ENABLE_BIT     5
`define DMACH_START_IRQ_ENABLE_BIT    4
`define DMACH_ABORT_IRQ_ENABLE_BIT    3
`define DMACH_FLAG_ADDR_ERR 0
`define DMACH_FLAG_ABORT    1
`define DMACH_FLAG_CELL     2
`define DMACH_FLAG_BLOCK    3
`define DMACH_FLAG_DHALF    4
`define DMACH_FLAG_DDONE    5
`define DMACH_FLAG_SHALF    6
`define DMACH_FLAG_SDONE    7

// Reset values and limits.
`define DMACH_RST_WORD      32'h0000_0000
`define DMACH_WORD_BYTES    9'h004
`define DMACH_ADDR_LIMIT    32'hFFFF_FFFF

`endif

// ---- dmach_pkg.sv ----
package dmach_pkg;

    typedef enum logic [1:0] {
        DMACH_IDLE  = 2'b00,
        DMACH_READ  = 2'b01,
        DMACH_WRITE = 2'b11
    } dmach_state_type;

    typedef struct packed {
        dmach_state_type state;
        logic            gon;
        logic            gsusp;
        logic [31:0]     ctrl;
        logic [31:0]     econ;
        logic [23:0]     intr;
        logic [31:0]     ssa;
        logic [31:0]     dsa;
        logic [7:0]      ssiz;
        logic [7:0]      dsiz;
        logic [7:0]      csiz;
        logic [7:0]      mdat;
        logic [7:0]      sptr;
        logic [7:0]      dptr;
        logic [8:0]      cptr;
        logic [8:0]      bcnt;
        logic [8:0]      nbytes;
        logic            pend_abort;
        logic            cell_busy;
        logic [31:0]     word;
        logic [31:0]     rdata;
        logic            rvalid;
        logic            mread;
        logic            mwrite;
        logic [31:0]     maddr;
        logic [31:0]     mwdata;
        logic [3:0]      mbe;
    } dmach_regs_type;

endpackage

// ---- dmach_chk_sva.sv ----
`timescale 1ns/1ps
module dmach_chk (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic        m_read,
    input wire logic        m_write,
    input wire logic [31:0] m_address,
    input wire logic [31:0] m_writedata,
    input wire logic [3:0]  m_byteenable,
    input wire logic [31:0] m_readdata,
    input wire logic        m_waitrequest,
    input wire logic        m_error
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////////////
    AST_RD_HOLD: assert property (m_read && m_waitrequest |=> m_read && $stable(m_address))
        else $error("Read request moved before acceptance.");
    AST_WR_HOLD: assert property (m_write && m_waitrequest |=> m_write && $stable(m_writedata))
        else $error("Write request moved before acceptance.");
    AST_WR_FOLLOWS: assert property (m_read && !m_waitrequest && !m_error |=> m_write)
        else $error("Accepted read not followed by a write.");
    AST_WR_DATA: assert property (m_read && !m_waitrequest && !m_error |=>
        m_writedata[7:0] == $past(m_readdata[7:0]))
        else $error("Written byte differs from the byte read.");
    AST_GAP: assert property (m_write && !m_waitrequest |=> !m_read && !m_write)
        else $error("No idle cycle after a write.");
    AST_EXCL: assert property (!(m_read && m_write))
        else $error("Read and write requested together.");
    AST_LANES: assert property (m_write |-> m_byteenable inside {4'h1,4'h3,4'h7,4'hF})
        else $error("Write lanes are not the low lanes.");
    AST_WR_CAUSE: assert property ($rose(m_write) |-> $past(m_read))
        else $error("Write without a preceding read.");
    AST_AVS_FIRST: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("Register read answer timing wrong.");
    AST_AVS_WR: assert property (avs_write |-> !avs_waitrequest)
        else $error("Register write was stalled.");
    ////////////////////////////////////////////////////////////////////////////////
    cover property (m_write && !m_waitrequest);
    cover property (m_read && m_waitrequest);
    cover property (m_read && !m_waitrequest && m_error);
endmodule

bind dmach_top dmach_chk dmach_chk_inst (
    .clk(clk), .nrst(nrst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .m_read(m_read), .m_write(m_write),
    .m_address(m_address), .m_writedata(m_writedata), .m_readdata(m_readdata),
    .m_waitrequest(m_waitrequest), .m_error(m_error), .m_byteenable(m_byteenable));

// ---- dmach_mem_model.sv ----
`timescale 1ns/1ps
module dmach_mem_model (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        m_read,
    input  wire logic        m_write,
    input  wire logic [31:0] m_address,
    input  wire logic [31:0] m_writedata,
    output logic      [31:0] m_readdata,
    output logic             m_waitrequest,
    output logic             m_error,
    input  wire logic        slow,
    input  wire logic        err_on,
    output logic      [15:0] wr_cnt,
    output logic      [31:0] last_waddr,
    output logic      [31:0] last_wdata
);
    logic [2:0] wait_r;
    logic       accept;
    logic [7:0] a;
    assign accept        = (m_read || m_write) && wait_r == 3'h0;
    assign m_waitrequest = !accept;
    assign m_error       = accept && err_on;
    assign a             = m_address[7:0];
    // Outside acceptance the data lines show the inverse so stale data cannot pass.
    assign m_readdata = (accept && m_read) ? {a + 8'h03, a + 8'h02, a + 8'h01, a}
                                           : ~{a + 8'h03, a + 8'h02, a + 8'h01, a};
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            wait_r     <= 3'h0;
            wr_cnt     <= 16'h0000;
            last_waddr <= 32'h0000_0000;
            last_wdata <= 32'h0000_0000;
        end
        else
        begin
            wait_r <= (accept || !(m_read || m_write)) ? (slow ? 3'h6 : 3'h0) : wait_r - 3'h1;
            if (accept && m_write)
            begin
                wr_cnt     <= wr_cnt + 16'h0001;
                last_waddr <= m_address;
                last_wdata <= m_writedata;
            end
        end
    end
endmodule

// ---- dmach_top_bench.sv ----
`timescale 1ns/1ps
`include "dmach_cfg.svh"
module dmach_top_bench;
    logic        clk, nrst, avs_read, avs_write, avs_waitrequest, dev_irq_valid;
    logic        m_read, m_write, m_waitrequest, m_error, chan_irq, slow, err_on;
    logic [7:0]  avs_address, dev_irq_num;
    logic [3:0]  avs_byteenable, m_byteenable;
    logic [31:0] avs_writedata, avs_readdata, m_address, m_writedata, m_readdata, rd;
    logic [31:0] last_waddr, last_wdata;
    logic [15:0] wr_cnt;
    int          error_cnt, cmp_count, n;
    dmach_top dmach_top_inst (.clk(clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .dev_irq_valid(dev_irq_valid),
        .dev_irq_num(dev_irq_num), .m_read(m_read), .m_write(m_write),
        .m_address(m_address), .m_writedata(m_writedata), .m_byteenable(m_byteenable),
        .m_readdata(m_readdata), .m_waitrequest(m_waitrequest), .m_error(m_error),
        .chan_irq(chan_irq));
    dmach_mem_model dmach_mem_model_inst (.clk(clk), .nrst(nrst), .m_read(m_read),
        .m_write(m_write), .m_address(m_address), .m_writedata(m_writedata),
        .m_readdata(m_readdata), .m_waitrequest(m_waitrequest), .m_error(m_error),
        .slow(slow), .err_on(err_on), .wr_cnt(wr_cnt), .last_waddr(last_waddr),
        .last_wdata(last_wdata));
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic timed_out(input string nm);
        chk(nm, 32'h0, 32'h1);
        give_verdict;
    endtask
    task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
        @(posedge clk);
        avs_address   <= adr;
        avs_read      <= !wr;
        avs_write     <= wr;
        avs_writedata <= wd;
        for (n = 0; n < 16; n++)
        begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 16) timed_out("register answer");
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] adr, input logic [31:0] m,
                       input logic [31:0] exp);
        bus(1'b0, adr, 32'h0);
        chk(nm, rd & m, exp);
    endtask
    task automatic wait_wr(input logic [15:0] k);
        for (n = 0; n < 300 && wr_cnt < k; n++) @(posedge clk);
        if (n == 300) timed_out("write wait");
        repeat (20) @(posedge clk);
        chk("write count", {16'h0, wr_cnt}, {16'h0, k});
    endtask
    task automatic go(input logic [7:0] sz, input logic [7:0] cs, input logic [31:0] ec);
        bus(1'b1, `DMACH_SSA_OFS, 32'h0000_0100);
        bus(1'b1, `DMACH_DSA_OFS, 32'h0000_0200);
        bus(1'b1, `DMACH_SSIZ_OFS, {24'h0, sz});
        bus(1'b1, `DMACH_DSIZ_OFS, {24'h0, sz});
        bus(1'b1, `DMACH_CSIZ_OFS, {24'h0, cs});
        bus(1'b1, `DMACH_INT_OFS, 32'h0000_00FF);
        bus(1'b1, `DMACH_CTRL_OFS, 32'h0000_0080);
        bus(1'b1, `DMACH_ECON_OFS, ec);
    endtask
    task automatic irq(input logic [7:0] num);
        @(posedge clk);
        dev_irq_valid <= 1'b1;
        dev_irq_num   <= num;
        @(posedge clk);
        dev_irq_valid <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        give_verdict;
    end
    initial
    begin
        {nrst, avs_read, avs_write, dev_irq_valid, slow, err_on} = 6'h00;
        {avs_address, dev_irq_num, avs_writedata} = 48'h0;
        avs_byteenable = 4'hF;
        error_cnt = 0;
        cmp_count = 0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        rdc("src_progress", `DMACH_SPTR_OFS, 32'hFFFF_FFFF, 32'h0);
        rdc("event_progress", `DMACH_CPTR_OFS, 32'hFFFF_FFFF, 32'h0);
        rdc("unmapped", 8'h3C, 32'hFFFF_FFFF, 32'h0);
        bus(1'b1, `DMACH_SPTR_OFS, 32'h0000_0055);
        rdc("src_progress", `DMACH_SPTR_OFS, 32'hFFFF_FFFF, 32'h0);
        $display("test reset done");
        bus(1'b1, `DMACH_GCTRL_OFS, 32'h0000_8000);
        bus(1'b1, `DMACH_MDAT_OFS, 32'h0000_0001);
        go(8'h08, 8'h04, 32'h0000_0080);
        wait_wr(16'h1);
        chk("write address", last_waddr, 32'h0000_0200);
        chk("write data", last_wdata, 32'h0302_0100);
        rdc("src_progress", `DMACH_SPTR_OFS, 32'hFF, 32'h04);
        rdc("dest_progress", `DMACH_DPTR_OFS, 32'hFF, 32'h04);
        rdc("event_progress", `DMACH_CPTR_OFS, 32'hFF, 32'h04);
        rdc("half flags", `DMACH_INT_OFS, 32'h50, 32'h50);
        bus(1'b1, `DMACH_ECON_OFS, 32'h0000_0080);
        wait_wr(16'h2);
        chk("write address", last_waddr, 32'h0000_0204);
        rdc("src_progress", `DMACH_SPTR_OFS, 32'hFF, 32'h00);
        rdc("dest_progress", `DMACH_DPTR_OFS, 32'hFF, 32'h00);
        rdc("done flags", `DMACH_INT_OFS, 32'hF8, 32'hF8);
        rdc("channel_enable", `DMACH_CTRL_OFS, 32'h80, 32'h00);
        bus(1'b1, `DMACH_ECON_OFS, 32'h0000_0080);
        wait_wr(16'h2);
        bus(1'b1, `DMACH_INT_OFS, 32'h0008_0000);
        @(posedge clk);
        chk("chan_irq", {31'h0, chan_irq}, 32'h1);
        bus(1'b1, `DMACH_INT_OFS, 32'h0008_0008);
        @(posedge clk);
        chk("chan_irq", {31'h0, chan_irq}, 32'h0);
        $display("test block done");
        bus(1'b1, `DMACH_GCTRL_OFS, 32'h0000_0000);
        go(8'h08, 8'h04, 32'h0000_0080);
        wait_wr(16'h2);
        rdc("src_progress", `DMACH_SPTR_OFS, 32'hFF, 32'h00);
        bus(1'b1, `DMACH_GCTRL_OFS, 32'h0000_8000);
        go(8'h08, 8'h04, 32'h0000_2510);
        irq(8'h24);
        wait_wr(16'h2);
        irq(8'h25);
        wait_wr(16'h3);
        rdc("src_progress", `DMACH_SPTR_OFS, 32'hFF, 32'h04);
        $display("test start sources done");
        bus(1'b1, `DMACH_SSA_OFS, 32'h0000_0100);
        rdc("src_progress", `DMACH_SPTR_OFS, 32'hFF, 32'h00);
        bus(1'b1, `DMACH_MDAT_OFS, 32'h0000_0002);
        go(8'h08, 8'h08, 32'h0000_00A0);
        wait_wr(16'h4);
        rdc("block flag", `DMACH_INT_OFS, 32'h08, 32'h08);
        rdc("channel_enable", `DMACH_CTRL_OFS, 32'h80, 32'h00);
        rdc("event_progress", `DMACH_CPTR_OFS, 32'hFF, 32'h00);
        $display("test match done");
        slow <= 1'b1;
        go(8'h08, 8'h08, 32'h0000_0080);
        for (n = 0; n < 50 && m_read !== 1'b1; n++) @(posedge clk);
        if (n == 50) timed_out("read start");
        bus(1'b1, `DMACH_ECON_OFS, 32'h0000_0040);
        wait_wr(16'h5);
        slow <= 1'b0;
        rdc("abort_flag", `DMACH_INT_OFS, 32'h02, 32'h02);
        rdc("src_progress", `DMACH_SPTR_OFS, 32'hFF, 32'h00);
        err_on <= 1'b1;
        go(8'h08, 8'h04, 32'h0000_0080);
        repeat (30) @(posedge clk);
        err_on <= 1'b0;
        rdc("error flag", `DMACH_INT_OFS, 32'h01, 32'h01);
        $display("test stops done");
        give_verdict;
    end
endmodule
